// file: sac_analog_model.sv
// Purpose: analog core stand-in that supplies the conversion code
// Assumes: the code only matters while a conversion runs
// Notes:   outside conversions the inverse is shown so stale values never match
`timescale 1ns/1ps
module sac_analog_model (
	// clock
	input wire logic       SYS_CLK,
	// from the control and the bench
	input wire logic       ANA_CONV_ACTIVE,
	input wire logic [9:0] code_val,
	// to the control
	output logic     [9:0] ANA_CODE
);
	always @(posedge SYS_CLK) begin
		ANA_CODE <= ANA_CONV_ACTIVE ? code_val : ~code_val;
	end
endmodule

// file: sac_consts.svh
// Purpose: offsets, field positions, reset values and counts of the converter control
// Assumes: byte offsets on a 32-bit AXI4-Lite bus, registers in the low byte
// Notes:   definitions only
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// register byte offsets
`define SAC_OFF_CHAN_REF    8'h00
`define SAC_OFF_CTRL_A      8'h04
`define SAC_OFF_CTRL_B      8'h08
`define SAC_OFF_RES_LOW     8'h0C
`define SAC_OFF_RES_HIGH    8'h10

// channel_reference_select_reg fields
`define SAC_REF_MSB         7
`define SAC_REF_LSB         6
`define SAC_LADJ_BIT        5
`define SAC_CH_MSB          4
`define SAC_CH_LSB          0

// converter_control_a fields
`define SAC_EN_BIT          7
`define SAC_START_BIT       6
`define SAC_ATE_BIT         5
`define SAC_FLAG_BIT        4
`define SAC_PRESC_MSB       2
`define SAC_PRESC_LSB       0

// converter_control_b fields
`define SAC_TRIG_MSB        2
`define SAC_TRIG_LSB        0
`define SAC_TRIG_FREE       3'h0

// reset values
`define SAC_RST_REG         8'h00
`define SAC_RST_FIRST       1'b1

// widths and counts
`define SAC_CODE_W          10
`define SAC_PCNT_W          7
`define SAC_CNT_W           5
`define SAC_NORMAL_CYCLES   5'd13
`define SAC_FIRST_CYCLES    5'd25
`define SAC_NUM_TRIG        7

// gain codes and bus responses
`define SAC_GAIN_1X         2'h0
`define SAC_GAIN_10X        2'h1
`define SAC_GAIN_200X       2'h2
`define SAC_RESP_OKAY       2'h0
`define SAC_RESP_SLVERR     2'h2
`endif

// file: sac_ctrl.sv
// Purpose: digital control of a 10-bit successive-approximation converter behind AXI4-Lite
// Assumes: trigger sources run on SYS_CLK; the analog code arrives asynchronously
// Notes:   the comparator and the analog mux sit outside; this block steers them
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "sac_consts.svh"

// Functional notes
// - result is a 10-bit code, zero at ground, full scale at reference minus one step
// - eight single-ended channels selectable, each against ground
// - sixteen differential combinations; two pairs carry 1x, 10x or 200x gain
// - seven differential channels share one negative terminal, positive freely chosen
// - channel select picks input; ground and bandgap single-ended; single-ended bypasses gain
// - reference select: external pin, supply, 1.1V or 2.56V; internal drives the pin
// - reference and channel act only while enabled; disabled converter draws no power
// - result in high and low bytes, right adjusted unless left-adjust set
// - reading the low byte blocks result updates; locked completions are lost
// - reading the high byte re-enables result updates
// - done flag is set even when the result was discarded by the lock
// - writing start begins one conversion; bit stays set until hardware clears it
// - channel change during a conversion applies only after it completes
// - auto-trigger enable starts conversions from the selected trigger source
// - rising edge of selected trigger resets prescaler and starts a conversion
// - trigger still high at completion, or edges during conversion, start nothing
// - done flag as source runs free, regardless of clearing that flag
// - start bit still works under auto trigger and reads one during any conversion
// - completion writes result, sets done flag and clears start in single mode
// - normal conversion takes 13 converter clocks, first after enable 25
// - prescaler counts while enabled and is held in reset while disabled
// - a start-bit request begins at the next converter clock rising edge
module sac_ctrl (
	// clock and reset
	input  wire logic                     SYS_CLK,
	input  wire logic                     SYS_RST,
	// axi4-lite write address
	input  wire logic                     S_AXI_AWVALID,
	output logic                          S_AXI_AWREADY,
	input  wire logic [7:0]               S_AXI_AWADDR,
	// axi4-lite write data
	input  wire logic                     S_AXI_WVALID,
	output logic                          S_AXI_WREADY,
	input  wire logic [31:0]              S_AXI_WDATA,
	input  wire logic [3:0]               S_AXI_WSTRB,
	// axi4-lite write response
	output logic                          S_AXI_BVALID,
	input  wire logic                     S_AXI_BREADY,
	output logic [1:0]                    S_AXI_BRESP,
	// axi4-lite read address
	input  wire logic                     S_AXI_ARVALID,
	output logic                          S_AXI_ARREADY,
	input  wire logic [7:0]               S_AXI_ARADDR,
	// axi4-lite read data
	output logic                          S_AXI_RVALID,
	input  wire logic                     S_AXI_RREADY,
	output logic [31:0]                   S_AXI_RDATA,
	output logic [1:0]                    S_AXI_RRESP,
	// trigger sources, selector codes 1 to 7
	input  wire logic [`SAC_NUM_TRIG-1:0] TRIG_IN,
	// analog core
	input  wire logic [`SAC_CODE_W-1:0]   ANA_CODE,
	output logic                          ANA_POWER_EN,
	output logic [1:0]                    ANA_REF_SEL,
	output logic                          ANA_REF_TO_PIN,
	output logic [4:0]                    ANA_CHANNEL,
	output logic                          ANA_GAIN_BYPASS,
	output logic [1:0]                    ANA_GAIN_SEL,
	output logic                          ANA_CONV_ACTIVE,
	output logic                          ANA_CONV_TICK,
	output logic                          ANA_FIRST_CONV
);

	sac_pkg::sac_state_s     q;
	sac_pkg::sac_state_s     n;
	logic                    trig_lvl;
	logic                    trig_edge;
	logic                    trig_fire;
	logic                    completing;
	logic                    track;
	logic                    wr_go;
	logic                    clr_flag;
	logic [`SAC_CNT_W-1:0]   len_last;
	logic [7:0]              wd;

	// last count of the prescaler; settings 0 and 1 both divide by two
	function automatic logic [`SAC_PCNT_W-1:0] presc_last(input logic [2:0] sel);
		logic [`SAC_PCNT_W:0] div;
		div = '0;
		if (sel == 3'h0) begin
			div[1] = 1'b1;
		end else begin
			div[sel] = 1'b1;
		end
		presc_last = div[`SAC_PCNT_W-1:0] - 1'b1;
	endfunction

	function automatic logic trig_pick(input logic [2:0] sel, input logic [`SAC_NUM_TRIG-1:0] src);
		trig_pick = 1'b0;
		if (sel != `SAC_TRIG_FREE) begin
			trig_pick = src[sel - 3'h1];
		end
	endfunction

	// returns {bypass, gain}; 0x00-07 single pins, 0x08-0F gained pairs,
	// 0x10-17 against the shared negative, 0x18-1D against the second, 0x1E/0x1F fixed inputs
	function automatic logic [2:0] gain_decode(input logic [4:0] ch);
		gain_decode = {1'b1, `SAC_GAIN_1X};
		if (ch[4:3] == 2'h1) begin
			gain_decode = {1'b0, (ch[1] ? `SAC_GAIN_200X : `SAC_GAIN_10X)};
		end else if (ch[4] && ch < 5'h1E) begin
			gain_decode = {1'b0, `SAC_GAIN_1X};
		end
	endfunction

	always_comb begin
		n = q;
		wd = q.wdata;
		clr_flag = 1'b0;
		n.tick = 1'b0;
		// analog code is asynchronous to SYS_CLK
		n.code_s1 = ANA_CODE;
		n.code_s2 = q.code_s1;

		trig_lvl = trig_pick(q.trigsel, TRIG_IN);
		n.trig_prev = trig_lvl;
		trig_edge = trig_lvl & ~q.trig_prev;
		// edge detection means a level still high at completion starts nothing
		trig_fire = q.en & q.ate & (q.trigsel != `SAC_TRIG_FREE) & trig_edge & (q.st == sac_pkg::ST_IDLE);
		len_last = q.first ? (`SAC_FIRST_CYCLES - 5'd1) : (`SAC_NORMAL_CYCLES - 5'd1);
		completing = (q.st == sac_pkg::ST_CONV) & q.tick & (q.cnt == len_last);

		// converter clock prescaler
		if (!q.en || trig_fire) begin
			n.pcnt = '0;
		end else if (q.pcnt == presc_last(q.presc)) begin
			n.pcnt = '0;
			n.tick = 1'b1;
		end else begin
			n.pcnt = q.pcnt + 1'b1;
		end

		case (q.st)
			sac_pkg::ST_IDLE: begin
				if (trig_fire) begin
					n.st = sac_pkg::ST_CONV;
					n.cnt = '0;
				end
			end
			sac_pkg::ST_WAIT: begin
				if (q.tick) begin
					n.st = sac_pkg::ST_CONV;
					n.cnt = '0;
				end
			end
			sac_pkg::ST_CONV: begin
				if (completing) begin
					if (!q.lock) begin
						n.res = q.code_s2;
					end
					n.first = 1'b0;
					n.cnt = '0;
					if (q.ate && q.trigsel == `SAC_TRIG_FREE) begin
						n.st = sac_pkg::ST_CONV;
					end else begin
						n.st = sac_pkg::ST_IDLE;
					end
				end else if (q.tick) begin
					n.cnt = q.cnt + 1'b1;
				end
			end
			default: begin
				n.st = sac_pkg::ST_IDLE;
			end
		endcase

		// selections follow the register only while enabled and between conversions
		track = q.en & ((q.st != sac_pkg::ST_CONV) | completing);
		if (track) begin
			n.conv_ch = q.chsel;
			n.conv_ref = q.refsel;
			{n.gain_byp, n.gain} = gain_decode(q.chsel);
		end

		// write channels
		wr_go = q.aw_got & q.w_got & ~q.bvalid;
		if (S_AXI_AWVALID && !q.aw_got && !q.bvalid) begin
			n.aw_got = 1'b1;
			n.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !q.w_got && !q.bvalid) begin
			n.w_got = 1'b1;
			n.wdata = S_AXI_WDATA[7:0];
			n.wstrb0 = S_AXI_WSTRB[0];
		end
		if (q.bvalid && S_AXI_BREADY) begin
			n.bvalid = 1'b0;
		end
		if (wr_go) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `SAC_RESP_OKAY;
			case ({q.awaddr[7:2], 2'h0})
				`SAC_OFF_CHAN_REF: begin
					if (q.wstrb0) begin
						n.refsel = wd[`SAC_REF_MSB:`SAC_REF_LSB];
						n.ladj = wd[`SAC_LADJ_BIT];
						n.chsel = wd[`SAC_CH_MSB:`SAC_CH_LSB];
					end
				end
				`SAC_OFF_CTRL_A: begin
					if (q.wstrb0) begin
						n.en = wd[`SAC_EN_BIT];
						n.ate = wd[`SAC_ATE_BIT];
						n.presc = wd[`SAC_PRESC_MSB:`SAC_PRESC_LSB];
						clr_flag = wd[`SAC_FLAG_BIT];
						// a start written while busy is already satisfied
						if (wd[`SAC_START_BIT] && wd[`SAC_EN_BIT] && n.st == sac_pkg::ST_IDLE) begin
							n.st = sac_pkg::ST_WAIT;
						end
					end
				end
				`SAC_OFF_CTRL_B: begin
					if (q.wstrb0) begin
						n.trigsel = wd[`SAC_TRIG_MSB:`SAC_TRIG_LSB];
					end
				end
				`SAC_OFF_RES_LOW, `SAC_OFF_RES_HIGH: begin
				end
				default: begin
					n.bresp = `SAC_RESP_SLVERR;
				end
			endcase
		end

		// read channels; data register is loaded at the address handshake
		if (S_AXI_ARVALID && !q.rvalid) begin
			n.rvalid = 1'b1;
			n.rresp = `SAC_RESP_OKAY;
			n.rdata = `SAC_RST_REG;
			case ({S_AXI_ARADDR[7:2], 2'h0})
				`SAC_OFF_CHAN_REF: begin
					n.rdata = {q.refsel, q.ladj, q.chsel};
				end
				`SAC_OFF_CTRL_A: begin
					n.rdata = {q.en, (q.st != sac_pkg::ST_IDLE), q.ate, q.flag, 1'b0, q.presc};
				end
				`SAC_OFF_CTRL_B: begin
					n.rdata = {5'h00, q.trigsel};
				end
				`SAC_OFF_RES_LOW: begin
					n.rdata = q.ladj ? {q.res[1:0], 6'h00} : q.res[7:0];
					n.lock = 1'b1;
				end
				`SAC_OFF_RES_HIGH: begin
					n.rdata = q.ladj ? q.res[9:2] : {6'h00, q.res[9:8]};
					n.lock = 1'b0;
				end
				default: begin
					n.rresp = `SAC_RESP_SLVERR;
				end
			endcase
		end else if (q.rvalid && S_AXI_RREADY) begin
			n.rvalid = 1'b0;
		end

		// set wins over a clear in the same cycle
		if (clr_flag) begin
			n.flag = 1'b0;
		end
		if (completing) begin
			n.flag = 1'b1;
		end

		// disabling aborts any conversion and re-arms the long first one
		if (!n.en) begin
			n.st = sac_pkg::ST_IDLE;
			n.first = `SAC_RST_FIRST;
			n.cnt = '0;
			// the prescaler looked at the old enable, so drop a tick landing on the disabling edge
			n.pcnt = '0;
			n.tick = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			q <= '0;
			q.first <= `SAC_RST_FIRST;
			q.st <= sac_pkg::ST_IDLE;
		end else begin
			q <= n;
		end
	end

	assign S_AXI_AWREADY = ~q.aw_got & ~q.bvalid;
	assign S_AXI_WREADY = ~q.w_got & ~q.bvalid;
	assign S_AXI_BVALID = q.bvalid;
	assign S_AXI_BRESP = q.bresp;
	assign S_AXI_ARREADY = ~q.rvalid;
	assign S_AXI_RVALID = q.rvalid;
	assign S_AXI_RDATA = {24'h000000, q.rdata};
	assign S_AXI_RRESP = q.rresp;

	// no bias current while disabled
	assign ANA_POWER_EN = q.en;
	assign ANA_REF_SEL = q.conv_ref;
	assign ANA_REF_TO_PIN = q.en & q.conv_ref[1];
	assign ANA_CHANNEL = q.conv_ch;
	assign ANA_GAIN_BYPASS = q.gain_byp;
	assign ANA_GAIN_SEL = q.gain;
	assign ANA_CONV_ACTIVE = (q.st == sac_pkg::ST_CONV);
	assign ANA_CONV_TICK = q.tick;
	assign ANA_FIRST_CONV = q.first;

endmodule

// file: sac_ctrl_assertions.sv
// Purpose: concurrent checks on the converter control ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound onto every sac_ctrl instance
`timescale 1ns/1ps
module sac_ctrl_checker (
	// clock and reset
	input wire logic        SYS_CLK,
	input wire logic        SYS_RST,
	// bus handshakes
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	// analog core
	input wire logic        ANA_POWER_EN,
	input wire logic [1:0]  ANA_REF_SEL,
	input wire logic        ANA_REF_TO_PIN,
	input wire logic [4:0]  ANA_CHANNEL,
	input wire logic        ANA_CONV_ACTIVE,
	input wire logic        ANA_CONV_TICK,
	input wire logic        ANA_FIRST_CONV
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_bhs;
		S_AXI_BVALID && S_AXI_BREADY;
	endsequence
	sequence s_conv_end;
		$fell(ANA_CONV_ACTIVE) && ANA_POWER_EN;
	endsequence

	AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
	AST_B_DONE: assert property (s_bhs |=> !S_AXI_BVALID) else $error("bvalid after handshake");
	AST_R_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read answer late");
	AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data not held");
	AST_REF_PIN: assert property (ANA_REF_TO_PIN == (ANA_POWER_EN && ANA_REF_SEL[1]))
		else $error("reference pin drive wrong");
	AST_OFF_IDLE: assert property (!ANA_POWER_EN |-> !ANA_CONV_ACTIVE && !ANA_CONV_TICK)
		else $error("activity while disabled");
	AST_TICK_GAP: assert property (ANA_CONV_TICK |=> !ANA_CONV_TICK) else $error("tick too fast");
	// the completion edge may reload the channel, so the cycle after a tick is exempt
	AST_FREEZE: assert property (ANA_CONV_ACTIVE && $past(ANA_CONV_ACTIVE) && !$past(ANA_CONV_TICK)
		|-> $stable(ANA_CHANNEL)) else $error("channel moved mid conversion");
	AST_FIRST_DONE: assert property (s_conv_end |-> ##[0:1] !ANA_FIRST_CONV)
		else $error("first flag kept");
endmodule

bind sac_ctrl sac_ctrl_checker sac_ctrl_checker_inst (.SYS_CLK, .SYS_RST, .S_AXI_BVALID, .S_AXI_BREADY,
	.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .ANA_POWER_EN,
	.ANA_REF_SEL, .ANA_REF_TO_PIN, .ANA_CHANNEL, .ANA_CONV_ACTIVE, .ANA_CONV_TICK, .ANA_FIRST_CONV);

// file: sac_ctrl_bench.sv
// Purpose: self-checking bench of the converter control
// Assumes: prescaler select 0, one tick every two clocks
// Notes:   tasks sample at the clock edge, so they see what the design saw
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_ctrl_bench;
	logic                     SYS_CLK, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
	logic                     S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	logic                     S_AXI_ARREADY, S_AXI_RVALID, ANA_POWER_EN, ANA_REF_TO_PIN, ANA_GAIN_BYPASS;
	logic                     ANA_CONV_ACTIVE, ANA_CONV_TICK, ANA_FIRST_CONV;
	logic [7:0]               S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0]              S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0]               S_AXI_WSTRB;
	logic [1:0]               S_AXI_BRESP, S_AXI_RRESP, ANA_REF_SEL, ANA_GAIN_SEL;
	logic [4:0]               ANA_CHANNEL;
	logic [`SAC_NUM_TRIG-1:0] TRIG_IN;
	logic [`SAC_CODE_W-1:0]   ANA_CODE, code_val;
	int                       n_errors, tests_run;
	logic [1:0]               last_bresp;

	sac_ctrl sac_ctrl_inst (.SYS_CLK, .SYS_RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR,
		.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_BVALID, .S_AXI_BREADY,
		.S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RREADY,
		.S_AXI_RDATA, .S_AXI_RRESP, .TRIG_IN, .ANA_CODE, .ANA_POWER_EN, .ANA_REF_SEL, .ANA_REF_TO_PIN,
		.ANA_CHANNEL, .ANA_GAIN_BYPASS, .ANA_GAIN_SEL, .ANA_CONV_ACTIVE, .ANA_CONV_TICK, .ANA_FIRST_CONV);
	sac_analog_model sac_analog_model_inst (.SYS_CLK, .ANA_CONV_ACTIVE, .code_val, .ANA_CODE);

	always #2.5 SYS_CLK = ~SYS_CLK;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// address and data offered together, each released at its own handshake
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge SYS_CLK);
		S_AXI_AWVALID <= 1'b1;
		S_AXI_AWADDR <= a;
		S_AXI_WVALID <= 1'b1;
		S_AXI_WDATA <= {24'h000000, d};
		while (!(aw && w)) begin
			@(posedge SYS_CLK);
			if (!aw && S_AXI_AWREADY === 1'b1) begin
				aw = 1'b1;
				S_AXI_AWVALID <= 1'b0;
			end
			if (!w && S_AXI_WREADY === 1'b1) begin
				w = 1'b1;
				S_AXI_WVALID <= 1'b0;
			end
		end
		// response accepted late on purpose so the slave has to hold it
		repeat (2) @(posedge SYS_CLK);
		S_AXI_BREADY <= 1'b1;
		do @(posedge SYS_CLK); while (S_AXI_BVALID !== 1'b1);
		last_bresp = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge SYS_CLK);
		S_AXI_ARVALID <= 1'b1;
		S_AXI_ARADDR <= a;
		do @(posedge SYS_CLK); while (S_AXI_ARREADY !== 1'b1);
		S_AXI_ARVALID <= 1'b0;
		// one cycle of back-pressure so the read data must stand
		@(posedge SYS_CLK);
		S_AXI_RREADY <= 1'b1;
		do @(posedge SYS_CLK); while (S_AXI_RVALID !== 1'b1);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, {24'h000000, e});
	endtask

	// counts converter ticks while busy; n of 0 only waits for the end
	task automatic conv(input int n);
		int k;
		k = 0;
		while (ANA_CONV_ACTIVE !== 1'b1) @(posedge SYS_CLK);
		while (ANA_CONV_ACTIVE === 1'b1) begin
			if (ANA_CONV_TICK === 1'b1) k++;
			@(posedge SYS_CLK);
		end
		if (n > 0) chk(32'(k), 32'(n));
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		rc(8'h00, 8'h00);
		rc(8'h04, 8'h00);
		rc(8'h08, 8'h00);
		chk(32'(ANA_FIRST_CONV), 32'h1);
		rd(8'h14, d, r);
		chk(32'(r), 32'h2);
		wr(8'h14, 8'h5A);
		chk(32'(last_bresp), 32'(`SAC_RESP_SLVERR));
		$display("t_reset done");
	endtask

	task automatic t_single();
		wr(8'h00, 8'hC5);
		chk(32'(last_bresp), 32'(`SAC_RESP_OKAY));
		wr(8'h04, 8'h80);
		wr(8'h04, 8'hC0);
		conv(25);
		rc(8'h04, 8'h90);
		chk(32'(ANA_CHANNEL), 32'h5);
		chk(32'(ANA_REF_SEL), 32'h3);
		chk(32'(ANA_REF_TO_PIN), 32'h1);
		chk(32'(ANA_GAIN_BYPASS), 32'h1);
		rc(8'h0C, 8'hA5);
		rc(8'h10, 8'h02);
		wr(8'h00, 8'hEA);
		rc(8'h0C, 8'h40);
		rc(8'h10, 8'hA9);
		chk(32'(ANA_GAIN_SEL), 32'h2);
		chk(32'(ANA_GAIN_BYPASS), 32'h0);
		wr(8'h00, 8'h0A);
		wr(8'h04, 8'hD0);
		conv(13);
		$display("t_single done");
	endtask

	task automatic t_lock();
		rc(8'h0C, 8'hA5);
		code_val <= 10'h155;
		wr(8'h04, 8'hD0);
		wr(8'h00, 8'h07);
		chk(32'(ANA_CHANNEL), 32'h0A);
		conv(0);
		rc(8'h04, 8'h90);
		chk(32'(ANA_CHANNEL), 32'h07);
		rc(8'h10, 8'h02);
		wr(8'h04, 8'hD0);
		conv(13);
		rc(8'h0C, 8'h55);
		rc(8'h10, 8'h01);
		$display("t_lock done");
	endtask

	task automatic t_trig();
		wr(8'h00, 8'h09);
		wr(8'h08, 8'h01);
		wr(8'h04, 8'hB0);
		@(posedge SYS_CLK);
		TRIG_IN <= 7'h01;
		// a second rising edge in mid conversion must be ignored
		fork
			begin
				repeat (8) @(posedge SYS_CLK);
				TRIG_IN <= 7'h00;
				@(posedge SYS_CLK);
				TRIG_IN <= 7'h01;
			end
		join_none
		conv(13);
		chk(32'(ANA_GAIN_SEL), 32'(`SAC_GAIN_10X));
		chk(32'(ANA_GAIN_BYPASS), 32'h0);
		@(posedge SYS_CLK);
		TRIG_IN <= 7'h02;
		repeat (20) @(posedge SYS_CLK);
		chk(32'(ANA_CONV_ACTIVE), 32'h0);
		rc(8'h04, 8'hB0);
		$display("t_trig done");
	endtask

	task automatic t_free();
		wr(8'h00, 8'h13);
		wr(8'h08, 8'h00);
		wr(8'h04, 8'hF0);
		repeat (200) @(posedge SYS_CLK);
		chk(32'(ANA_CONV_ACTIVE), 32'h1);
		chk(32'(ANA_GAIN_SEL), 32'(`SAC_GAIN_1X));
		chk(32'(ANA_GAIN_BYPASS), 32'h0);
		rc(8'h04, 8'hF0);
		wr(8'h04, 8'h00);
		chk(32'(ANA_CONV_ACTIVE), 32'h0);
		chk(32'(ANA_POWER_EN), 32'h0);
		chk(32'(ANA_FIRST_CONV), 32'h1);
		$display("t_free done");
	endtask

	initial begin
		SYS_CLK = 1'b0;
		SYS_RST = 1'b1;
		S_AXI_AWVALID = 1'b0;
		S_AXI_WVALID = 1'b0;
		S_AXI_BREADY = 1'b0;
		S_AXI_ARVALID = 1'b0;
		S_AXI_RREADY = 1'b0;
		S_AXI_AWADDR = 8'h00;
		S_AXI_ARADDR = 8'h00;
		S_AXI_WDATA = 32'h00000000;
		S_AXI_WSTRB = 4'hF;
		TRIG_IN = 7'h00;
		code_val = 10'h2A5;
		n_errors = 0;
		tests_run = 0;
		repeat (10) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		t_reset();
		t_single();
		t_lock();
		t_trig();
		t_free();
		report_and_stop();
	end

	// the whole sequence needs a few hundred clocks
	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end
endmodule

// file: sac_pkg.sv
// Purpose: types of the converter control
// Assumes: sac_consts.svh gives the widths
// Notes:   one packed struct holds all state of the control module
`include "sac_consts.svh"
package sac_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} sac_conv_e;

	typedef struct packed {
		logic                     aw_got;
		logic [7:0]               awaddr;
		logic                     w_got;
		logic [7:0]               wdata;
		logic                     wstrb0;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [7:0]               rdata;
		logic [1:0]               rresp;
		logic [4:0]               chsel;
		logic                     ladj;
		logic [1:0]               refsel;
		logic                     en;
		logic                     ate;
		logic                     flag;
		logic [2:0]               presc;
		logic [2:0]               trigsel;
		logic [4:0]               conv_ch;
		logic [1:0]               conv_ref;
		logic                     gain_byp;
		logic [1:0]               gain;
		logic                     first;
		logic [`SAC_CNT_W-1:0]    cnt;
		logic [`SAC_PCNT_W-1:0]   pcnt;
		logic                     tick;
		logic                     trig_prev;
		logic                     lock;
		logic [`SAC_CODE_W-1:0]   res;
		logic [`SAC_CODE_W-1:0]   code_s1;
		logic [`SAC_CODE_W-1:0]   code_s2;
		sac_conv_e                st;
	} sac_state_s;
endpackage
